// ### hdl/hpst_pkg.sv
// Constants, field layouts and carrier types of the host port block.
// Assumes one system clock; serial, interrupt and status pins are resynchronised inside the block, micro_step and micro_dir are not.
// Operation
// R1 - One frame: address byte plus four data bytes
// R2 - Every register moves as a full 32-bit word
// R3 - Address top bit: 0 read, 1 write
// R4 - Direction bit is datagram bit 39, sent first
// R5 - Access type decided per register address
// R6 - Sine table RAM: 8192 words of 12 bits
// R7 - Table written and read through separate addresses
// R8 - Table read data returned one datagram late
// R9 - Host loads whole table after power-up
// R10 - Host fills table with absolute sine values
// R11 - Chopper clock is system clock over divider
// R12 - Host keeps chopper between 25 and 50 kHz
// R13 - Masked interrupt condition pulls open-drain output low
// R14 - Readable fixed type and version code
// R15 - Programmable microstep resolution sets table step
// R16 - Sequencer drives decay, current scale, stall threshold
// R17 - Readable register captures driver status bits
// R18 - Only complete 40-bit frames commit writes
package hpst_pkg;

  // ----------------------------------------
  // Datagram layout
  // ----------------------------------------
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned DATA_BITS = 32;
  localparam int unsigned RW_BIT = 39;
  localparam int unsigned ADDR_HI = 38;
  localparam int unsigned ADDR_LO = 32;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h07;
  localparam logic [5:0] FRAME_CNT = 6'h28;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [6:0] REG_SEQ_CFG = 7'h40;
  localparam logic [6:0] REG_CHOP_DIV = 7'h41;
  localparam logic [6:0] REG_IRQ_MASK = 7'h42;
  localparam logic [6:0] REG_IRQ_PEND = 7'h43;
  localparam logic [6:0] REG_DRV_STAT = 7'h44;
  localparam logic [6:0] REG_TYPE_VER = 7'h45;
  localparam logic [6:0] REG_LUT_WR = 7'h46;
  localparam logic [6:0] REG_LUT_RD = 7'h47;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned LUT_WADDR_LO = 16;
  localparam int unsigned LUT_ADDR_W = 13;
  localparam int unsigned LUT_DATA_W = 12;
  localparam int unsigned CHOP_W = 16;
  localparam int unsigned IRQ_W = 8;
  localparam int unsigned DRV_STAT_W = 8;
  localparam logic [15:0] CHOP_DIV_RST = 16'h0000;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [3:0] RES_MAX = 4'hC;

  typedef struct packed {
    logic [6:0] stall_thr;
    logic [7:0] cur_scale;
    logic mixed_decay;
    logic [3:0] resolution;
  } hpst_seq_cfg_t;

  localparam hpst_seq_cfg_t SEQ_CFG_RST = '0;

endpackage : hpst_pkg

// ### hdl/hpst_host_port.sv
// Host serial port, sine table RAM, sequencer controls, chopper clock, interrupt pin.
// Assumes serial clock well below a quarter of the system clock; serial, interrupt and status pins are asynchronous, micro_step and micro_dir are not.
`timescale 1ns/1ps
module hpst_host_port
  import hpst_pkg::*;
#(
  parameter logic [31:0] TYPE_VERSION = 32'h0000_0001, // Arbitrary identity value
  parameter int unsigned LUT_DEPTH = 8192
)(
  input wire logic clock,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [IRQ_W-1:0] irq_cond,
  output logic irq_out_n,
  output logic irq_out_n_oe,
  input wire logic [DRV_STAT_W-1:0] drv_status,
  input wire logic micro_step,
  input wire logic micro_dir,
  output hpst_seq_cfg_t seq_cfg,
  output logic [LUT_DATA_W-1:0] phase_amp,
  output logic chopper_clock_out
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (LUT_DEPTH != (1 << LUT_ADDR_W))
  begin : g_depth_chk
    $error("LUT_DEPTH must equal two to the table address width");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sck_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] mosi_s_q;
  logic [IRQ_W-1:0] irq_s1_q, irq_s2_q;
  logic [DRV_STAT_W-1:0] drv_s1_q, drv_s2_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      drv_s1_q <= '0;
      drv_s2_q <= '0;
    end
    else
    begin
      sck_s_q <= {sck_s_q[1:0], spi_sck};
      cs_s_q <= {cs_s_q[1:0], spi_cs_n};
      mosi_s_q <= {mosi_s_q[0], spi_mosi};
      irq_s1_q <= irq_cond;
      irq_s2_q <= irq_s1_q;
      drv_s1_q <= drv_status;
      drv_s2_q <= drv_s1_q;
    end
  end

  wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
  wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
  wire cs_act = ~cs_s_q[1];
  wire cs_fall = ~cs_s_q[1] & cs_s_q[2];
  wire cs_rise = cs_s_q[1] & ~cs_s_q[2];

  // ----------------------------------------
  // Receive shifter
  // ----------------------------------------
  logic [FRAME_BITS-1:0] rx_q;
  logic [5:0] cnt_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rx_q <= '0;
      cnt_q <= 6'h00;
    end
    else if (cs_fall)
      cnt_q <= 6'h00;
    else if (cs_act && sck_rise)
    begin
      rx_q <= {rx_q[FRAME_BITS-2:0], mosi_s_q[1]}; // [R1] [R4]
      if (cnt_q != CNT_MAX)
        cnt_q <= cnt_q + 6'h01;
    end
  end

  // Short or long frames never commit, so a glitch on select cannot corrupt state
  wire commit = cs_rise && (cnt_q == FRAME_CNT); // [R18]
  wire is_write = rx_q[RW_BIT]; // [R3]
  wire [6:0] wr_addr = rx_q[ADDR_HI:ADDR_LO];
  wire [DATA_BITS-1:0] wr_data = rx_q[DATA_BITS-1:0]; // [R2]
  wire do_write = commit && is_write;
  wire wr_seq = do_write && (wr_addr == REG_SEQ_CFG);
  wire wr_chop = do_write && (wr_addr == REG_CHOP_DIV);
  wire wr_mask = do_write && (wr_addr == REG_IRQ_MASK);
  wire wr_lut = do_write && (wr_addr == REG_LUT_WR); // [R7]
  wire rd_lut = commit && !is_write && (wr_addr == REG_LUT_RD); // [R7]
  // Clamp on write, so readback shows the resolution really in use
  wire [3:0] wr_res = (wr_data[3:0] > RES_MAX) ? RES_MAX : wr_data[3:0]; // [R15]

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  hpst_seq_cfg_t seq_cfg_q;
  logic [CHOP_W-1:0] chop_div_q;
  logic [IRQ_W-1:0] irq_mask_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      seq_cfg_q <= SEQ_CFG_RST;
      chop_div_q <= CHOP_DIV_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else
    begin
      if (wr_seq)
        seq_cfg_q <= {wr_data[$bits(hpst_seq_cfg_t)-1:4], wr_res}; // [R15] [R16]
      if (wr_chop)
        chop_div_q <= wr_data[CHOP_W-1:0];
      if (wr_mask)
        irq_mask_q <= wr_data[IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Sine table RAM
  // ----------------------------------------
  logic [LUT_DATA_W-1:0] lut_mem [LUT_DEPTH]; // [R6]
  logic [LUT_ADDR_W-1:0] lut_raddr_q;
  logic [LUT_DATA_W-1:0] lut_rdata_q;
  logic [LUT_ADDR_W-1:0] phase_q;
  logic [LUT_DATA_W-1:0] amp_q;

  // Table content is undefined after reset; the host loads it before use
  always_ff @(posedge clock)
  begin
    if (wr_lut)
      lut_mem[wr_data[LUT_WADDR_LO+LUT_ADDR_W-1:LUT_WADDR_LO]] <= wr_data[LUT_DATA_W-1:0];
  end

  // Read address taken at frame end, data shown in the next read frame
  always_ff @(posedge clock)
  begin
    if (reset)
      lut_raddr_q <= '0;
    else if (rd_lut)
      lut_raddr_q <= wr_data[LUT_ADDR_W-1:0]; // [R8]
  end

  always_ff @(posedge clock)
  begin
    lut_rdata_q <= lut_mem[lut_raddr_q]; // [R8]
    amp_q <= lut_mem[phase_q];
  end

  // ----------------------------------------
  // Microstep sequencer
  // ----------------------------------------
  wire [3:0] res_eff = (seq_cfg_q.resolution > RES_MAX) ? RES_MAX : seq_cfg_q.resolution;
  wire [LUT_ADDR_W-1:0] step_size = LUT_ADDR_W'(1) << res_eff; // [R15]

  always_ff @(posedge clock)
  begin
    if (reset)
      phase_q <= '0;
    else if (micro_step)
      phase_q <= micro_dir ? (phase_q - step_size) : (phase_q + step_size); // [R15]
  end

  // ----------------------------------------
  // Read multiplexer and transmit shifter
  // ----------------------------------------
  wire [6:0] rd_addr = {rx_q[5:0], mosi_s_q[1]};
  wire rd_dir_write = rx_q[6];
  wire [DATA_BITS-1:0] rd_seq = DATA_BITS'(seq_cfg_q);
  wire [DATA_BITS-1:0] rd_chop = DATA_BITS'(chop_div_q);
  wire [DATA_BITS-1:0] rd_mask = DATA_BITS'(irq_mask_q);
  wire [DATA_BITS-1:0] rd_pend = DATA_BITS'(irq_s2_q & irq_mask_q);
  wire [DATA_BITS-1:0] rd_drv = DATA_BITS'(drv_s2_q); // [R17]
  wire [DATA_BITS-1:0] rd_lutd = DATA_BITS'(lut_rdata_q); // [R8]
  // Write-only addresses and write frames answer zero
  wire [DATA_BITS-1:0] rd_mux =
    rd_dir_write ? '0 :
    (rd_addr == REG_SEQ_CFG) ? rd_seq :
    (rd_addr == REG_CHOP_DIV) ? rd_chop :
    (rd_addr == REG_IRQ_MASK) ? rd_mask :
    (rd_addr == REG_IRQ_PEND) ? rd_pend :
    (rd_addr == REG_DRV_STAT) ? rd_drv :
    (rd_addr == REG_TYPE_VER) ? TYPE_VERSION :
    (rd_addr == REG_LUT_RD) ? rd_lutd : '0; // [R5] [R14]

  logic [DATA_BITS-1:0] tx_q;
  logic miso_q;
  logic miso_oe_q;
  wire load_tx = cs_act && sck_rise && (cnt_q == ADDR_LAST_BIT);
  wire shift_tx = cs_act && sck_fall && (cnt_q >= (ADDR_LAST_BIT + 6'h01));

  always_ff @(posedge clock)
  begin
    if (reset || cs_fall)
    begin
      tx_q <= '0;
      miso_q <= 1'b0;
    end
    else if (load_tx)
      tx_q <= rd_mux; // [R2]
    else if (shift_tx)
    begin
      miso_q <= tx_q[DATA_BITS-1];
      tx_q <= {tx_q[DATA_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      miso_oe_q <= 1'b0;
    else
      miso_oe_q <= cs_act;
  end

  // ----------------------------------------
  // Chopper clock divider
  // ----------------------------------------
  logic [CHOP_W-1:0] chop_cnt_q;
  logic chop_q;

  // Divider of zero stops the clock rather than running at an unsafe rate
  always_ff @(posedge clock)
  begin
    if (reset || (chop_div_q == '0))
    begin
      chop_cnt_q <= '0;
      chop_q <= 1'b0;
    end
    else
    begin
      chop_cnt_q <= (chop_cnt_q >= (chop_div_q - CHOP_W'(1))) ? '0 : (chop_cnt_q + CHOP_W'(1)); // [R11]
      chop_q <= (chop_cnt_q < (chop_div_q >> 1)); // [R11]
    end
  end

  // ----------------------------------------
  // Interrupt pin and outputs
  // ----------------------------------------
  logic irq_n_q;
  logic irq_oe_q;
  hpst_seq_cfg_t seq_out_q;
  logic [LUT_DATA_W-1:0] amp_out_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_n_q <= 1'b1;
      irq_oe_q <= 1'b0;
      seq_out_q <= SEQ_CFG_RST;
      amp_out_q <= '0;
    end
    else
    begin
      irq_n_q <= ~|(irq_s2_q & irq_mask_q);
      irq_oe_q <= |(irq_s2_q & irq_mask_q); // [R13]
      seq_out_q <= seq_cfg_q; // [R16]
      amp_out_q <= amp_q;
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;
  assign irq_out_n = irq_n_q;
  assign irq_out_n_oe = irq_oe_q;
  assign seq_cfg = seq_out_q;
  assign phase_amp = amp_out_q;
  assign chopper_clock_out = chop_q;

endmodule : hpst_host_port

// ### test/hpst_host_port_asserts.sv
// Port checker for the host port block.
// Assumes it is bound to hpst_host_port with one clock and a synchronous reset.
`timescale 1ns/1ps
module hpst_host_port_asserts
  import hpst_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic [IRQ_W-1:0] irq_cond,
  input wire logic irq_out_n,
  input wire logic irq_out_n_oe,
  input wire logic [DRV_STAT_W-1:0] drv_status,
  input wire logic micro_step,
  input wire logic micro_dir,
  input wire hpst_seq_cfg_t seq_cfg,
  input wire logic [LUT_DATA_W-1:0] phase_amp,
  input wire logic chopper_clock_out
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  rst_vals_a: assert property ($fell(reset) |-> seq_cfg == SEQ_CFG_RST && !spi_miso_oe && irq_out_n)
    else $error("outputs not idle after reset");
  chop_rst_a: assert property ($fell(reset) |-> !chopper_clock_out [*8])
    else $error("chopper runs before divider write");
  irq_pair_a: assert property (irq_out_n_oe == !irq_out_n)
    else $error("irq enable and level disagree");
  irq_quiet_a: assert property ((irq_cond == '0) [*4] |-> irq_out_n)
    else $error("irq low without condition");
  miso_off_a: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  oe_sel_a: assert property ($rose(spi_miso_oe) |-> !spi_cs_n)
    else $error("miso enabled without select");
  cfg_frame_a: assert property (!$stable(seq_cfg) |-> spi_cs_n)
    else $error("config changed inside a frame");
  res_clamp_a: assert property (seq_cfg.resolution <= RES_MAX)
    else $error("resolution above limit");
  miso_hold_a: assert property (!$stable(spi_miso) |-> !spi_sck)
    else $error("miso changed while clock high");
  amp_hold_a: assert property (!$stable(phase_amp) |-> spi_cs_n || $past(micro_step, 3))
    else $error("amplitude changed without cause");
endmodule : hpst_host_port_asserts

bind hpst_host_port hpst_host_port_asserts chk_i (.clock, .reset, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso,
  .spi_miso_oe, .irq_cond, .irq_out_n, .irq_out_n_oe, .drv_status, .micro_step, .micro_dir, .seq_cfg,
  .phase_amp, .chopper_clock_out);

// ### test/hpst_spi_host.sv
// Host side model: serial master, mode 0, about twenty clocks per bit.
// Assumes the caller enters xfer on a falling clock edge.
`timescale 1ns/1ps
module hpst_spi_host (
  input wire logic clock,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial
  begin
    spi_sck = 0;
    spi_cs_n = 1;
    spi_mosi = 0;
  end
  task automatic hold(int n);
    repeat (n) @(negedge clock);
  endtask : hold
  // ----
  // Frame: MSB first, n below 40 gives a cut frame
  // ----
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    spi_cs_n = 0;
    for (int i = 0; i < n; i++)
    begin
      spi_mosi = tx[39-i];
      hold(10);
      rx = {rx[38:0], spi_miso};
      spi_sck = 1;
      hold(10);
      spi_sck = 0;
    end
    hold(10);
    spi_cs_n = 1;
    spi_mosi = ~spi_mosi; // Last bit inverted, no stale value
    hold(10);
  endtask : xfer
endmodule : hpst_spi_host

// ### test/tb.sv
// Self-checking bench for hpst_host_port.
// Assumes the serial master model and the port checker.
`timescale 1ns/1ps
module tb;
  import hpst_pkg::*;
  localparam logic [31:0] TV = 32'h0000_5A01; // Arbitrary identity value
  logic clock = 0;
  logic reset = 1;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, irq_out_n, irq_out_n_oe, chopper_clock_out;
  logic micro_step = 0;
  logic micro_dir = 0;
  logic [7:0] irq_cond = '0;
  logic [7:0] drv_status = '0;
  logic [11:0] phase_amp;
  hpst_seq_cfg_t seq_cfg;
  logic [39:0] rx;
  int error_cnt = 0;
  int checked = 0;
  wire miso_seen = spi_miso_oe ? spi_miso : !spi_miso;
  always #2.5 clock = ~clock;
  hpst_host_port #(.TYPE_VERSION(TV)) dut (.clock, .reset, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .irq_cond, .irq_out_n, .irq_out_n_oe, .drv_status, .micro_step, .micro_dir, .seq_cfg,
    .phase_amp, .chopper_clock_out);
  hpst_spi_host m (.clock, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso(miso_seen));
  // ----
  // Helpers
  // ----
  task automatic complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [39:0] got, logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [6:0] a, logic [31:0] d);
    m.xfer({1'b1, a, d}, 40, rx);
  endtask : wr
  task automatic rdc(string nm, logic [6:0] a, logic [31:0] d, logic [31:0] exp);
    m.xfer({1'b0, a, d}, 40, rx);
    chk(nm, rx[31:0], exp);
  endtask : rdc
  task automatic step(logic dir);
    micro_dir = dir;
    micro_step = 1;
    @(negedge clock);
    micro_step = 0;
    repeat (4) @(negedge clock);
  endtask : step
  task automatic lvl(logic v, output int n);
    n = 0;
    while (chopper_clock_out === v && n < 6000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 6000)
    begin
      error_cnt++;
      complete_run;
    end
  endtask : lvl
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    chk("rst", {spi_miso_oe, irq_out_n_oe, irq_out_n, chopper_clock_out, seq_cfg}, 24'h20_0000);
    reset = 0;
    repeat (5) @(negedge clock);
    rdc("type", REG_TYPE_VER, 0, TV);
    rdc("unmapped", 7'h10, 0, 0);
    rdc("lut_wr", REG_LUT_WR, 0, 0);
    wr(REG_SEQ_CFG, 32'h000F_FFEF);
    chk("clamp", seq_cfg, 20'hF_FFEC);
    wr(REG_SEQ_CFG, 32'hFFF5_5552);
    chk("cfg", seq_cfg, 20'h5_5552);
    rdc("cfg_rd", REG_SEQ_CFG, 0, 32'h0005_5552);
    m.xfer({1'b1, REG_SEQ_CFG, 32'h0}, 39, rx);
    chk("cut", seq_cfg, 20'h5_5552);
    drv_status = 8'hA5;
    wr(REG_DRV_STAT, 0);
    rdc("drv", REG_DRV_STAT, 0, 32'hA5);
    wr(REG_SEQ_CFG, 0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_lut;
    wr(REG_LUT_WR, {3'h0, 13'h0001, 4'h0, 12'hABC});
    wr(REG_LUT_WR, {3'h0, 13'h1FFF, 4'h0, 12'h123});
    wr(REG_LUT_WR, {3'h0, 13'h0000, 4'h0, 12'hFFF});
    rdc("lut0", REG_LUT_RD, 32'h1FFF, 32'hFFF);
    rdc("lut1", REG_LUT_RD, 32'h1, 32'h123);
    m.xfer({1'b0, REG_LUT_RD, 32'h0}, 39, rx);
    rdc("lut2", REG_LUT_RD, 0, 32'hABC);
    step(0);
    chk("amp_up", phase_amp, 12'hABC);
    step(1);
    step(1);
    chk("amp_wrap", phase_amp, 12'h123);
    $display("t_lut done");
  endtask : t_lut
  task automatic t_irq;
    wr(REG_IRQ_MASK, 32'h5);
    rdc("mask", REG_IRQ_MASK, 0, 32'h5);
    irq_cond = 8'h0A;
    repeat (5) @(negedge clock);
    chk("irq_off", {irq_out_n, irq_out_n_oe}, 2'b10);
    irq_cond = 8'h0C;
    repeat (5) @(negedge clock);
    chk("irq_on", {irq_out_n, irq_out_n_oe}, 2'b01);
    rdc("pend", REG_IRQ_PEND, 0, 32'h4);
    irq_cond = '0;
    $display("t_irq done");
  endtask : t_irq
  task automatic t_chop;
    int n, hi, lo;
    wr(REG_CHOP_DIV, 32'h0000_15B4);
    lvl(1, n);
    lvl(0, n);
    lvl(1, hi);
    lvl(0, lo);
    chk("chop_hi", hi, 2778);
    chk("chop_lo", lo, 2778);
    $display("t_chop done");
  endtask : t_chop
  initial
  begin
    repeat (20) @(negedge clock);
    t_regs;
    t_lut;
    t_irq;
    t_chop;
    complete_run;
  end
endmodule : tb
